// [verilog/ohv_hiccup_top.sv]
// overcurrent hiccup supervisor with voltage code decode and
// a classic wishbone register slave
// assumes one 50 MHz clock, comparator flags and code pins that
// arrive asynchronously, and pwm demand from logic on this clock
//
// Our own choices: the address map and the Wishbone register port.
`timescale 1ns/10ps
`include "ohv_consts.svh"

// What this block does
// - both channel flags together raise event at once
// - one flag for seven cycles raises event
// - event forces all gate drives off
// - first wait lasts 4096 switching cycles
// - wait ends in soft-start, success resumes switching
// - failed soft-start waits 2048 cycles, retries
// - hiccup loop repeats forever while enabled
// - three tables decode code word to reference
// - undriven code pins read as one
// - first 5-bit table from 0.800 to 1.550
// - second 5-bit table from 1.100 to 1.850
// - 6-bit table, fine bit low, 12.5 mV
// - off code keeps device disabled until changed
module ohv_hiccup_top #(
   parameter int SW_DIV = `OHV_SW_DIV,
   parameter int FIRST_WAIT = `OHV_FIRST_WAIT,
   parameter int RETRY_WAIT = `OHV_RETRY_WAIT,
   parameter int PERSIST = `OHV_PERSIST_CYC,
   parameter int SS_DELAY = `OHV_SS_DELAY,
   parameter int SS_STEP = `OHV_SS_STEP
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // comparator flags and enable pin
   input wire logic [1:0] ocFlag,
   input wire logic enablePin,
   // code pins: level and whether someone drives it
   input wire logic [5:0] vcodeLevel,
   input wire logic [5:0] vcodeDrive,
   // pwm demand per channel
   input wire logic [1:0] pwmDemand,
   // gate drives
   output logic [1:0] highGate,
   output logic [1:0] lowGate,
   // reference and ramp
   output logic [`OHV_STEP_W-1:0] referenceLevel,
   output logic [`OHV_STEP_W-1:0] rampLevel,
   output logic referenceOff,
   // status
   output logic overcurrentEvent,
   output logic hiccupActive
);
   localparam int DIV_W = $clog2(SW_DIV + 1);
   localparam int WAIT_W = $clog2(FIRST_WAIT + 1);
   localparam int PER_W = $clog2(PERSIST + 1);
   localparam int SS_W = $clog2(SS_DELAY + SS_STEP + 1);

   // ********************
   // elaboration checks
   // ********************
   if (SW_DIV < 1 || PERSIST < 1 || SS_DELAY < 1 || SS_STEP < 1) begin : gBadCount
      $error("ohv_hiccup_top: counts must be at least one");
   end
   if (FIRST_WAIT < 1 || RETRY_WAIT < 1 || RETRY_WAIT > FIRST_WAIT) begin : gBadWait
      $error("ohv_hiccup_top: waits must be positive, retry not above first");
   end

   // ********************
   // declarations
   // ********************
   logic [1:0] ocSync;
   logic enSync;
   logic [5:0] levelSync;
   logic [5:0] driveSync;
   logic [5:0] vcodeBit;
   logic codeOff;
   logic [`OHV_STEP_W-1:0] refSteps;
   logic [DIV_W-1:0] div_q;
   logic swTick;
   logic [1:0] held_q;
   logic [PER_W-1:0] persist_q [2];
   logic [1:0] persistHit;
   logic ocBoth;
   logic ocEvt;
   logic runAllowed;
   ohv_pkg::ohv_state_t state_q;
   ohv_pkg::ohv_state_t state_d;
   logic [WAIT_W-1:0] wait_q;
   logic [WAIT_W-1:0] waitLen_q;
   logic [SS_W-1:0] ss_q;
   logic ssDelayDone_q;
   logic [`OHV_STEP_W-1:0] ramp_q;
   logic rampDone;
   logic driveOn;
   logic ctrlEn_q;
   ohv_pkg::ohv_table_t tbl_q;
   logic sticky_q;
   logic ack_q;
   logic wbReq;
   logic wbWrite;
   logic [31:0] rdData;

   // ********************
   // pin synchronisers
   // ********************
   ohv_sync #(.WIDTH(3), .RESET_VAL(1'b0)) uSyncFlag (
      .clk(clk),
      .rst_b(rst_b),
      .asyncIn({enablePin, ocFlag}),
      .syncOut({enSync, ocSync})
   );

   ohv_sync #(.WIDTH(6), .RESET_VAL(1'b1)) uSyncLevel (
      .clk(clk),
      .rst_b(rst_b),
      .asyncIn(vcodeLevel),
      .syncOut(levelSync)
   );

   ohv_sync #(.WIDTH(6), .RESET_VAL(1'b0)) uSyncDrive (
      .clk(clk),
      .rst_b(rst_b),
      .asyncIn(vcodeDrive),
      .syncOut(driveSync)
   );

   // an undriven pin sits at its weak pull-up
   assign vcodeBit = levelSync | ~driveSync;

   // ********************
   // code decode
   // ********************
   ohv_code_decode uDecode (
      .clk(clk),
      .rst_b(rst_b),
      .vcodeBit(vcodeBit),
      .tableSel(tbl_q),
      .codeOff_q(codeOff),
      .steps_q(refSteps)
   );

   assign referenceLevel = refSteps;
   assign referenceOff = codeOff;

   // ********************
   // switching cycle divider
   // ********************
   assign swTick = (div_q == DIV_W'(SW_DIV - 1));

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         div_q <= '0;
      end else if (swTick) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 1'b1;
      end
   end

   // ********************
   // overcurrent qualification
   // ********************
   // a flag low at any point of a switching cycle clears its run
   for (genvar ch = 0; ch < 2; ch++) begin : gChan
      always_ff @(posedge clk) begin
         if (!rst_b || !driveOn) begin
            held_q[ch] <= 1'b1;
            persist_q[ch] <= '0;
         end else if (swTick) begin
            held_q[ch] <= 1'b1;
            if (held_q[ch] && ocSync[ch] && !persistHit[ch]) begin
               persist_q[ch] <= persist_q[ch] + 1'b1;
            end else if (!(held_q[ch] && ocSync[ch])) begin
               persist_q[ch] <= '0;
            end
         end else if (!ocSync[ch]) begin
            held_q[ch] <= 1'b0;
         end
      end
      assign persistHit[ch] = (persist_q[ch] == PER_W'(PERSIST));
   end

   assign ocBoth = &ocSync;
   assign driveOn = (state_q == ohv_pkg::OHV_S_SOFT) || (state_q == ohv_pkg::OHV_S_RUN);
   assign ocEvt = driveOn && (ocBoth || (|persistHit));
   assign runAllowed = ctrlEn_q && enSync && !codeOff;

   // ********************
   // supervision state machine
   // ********************
   assign rampDone = ssDelayDone_q && (ramp_q >= refSteps);

   always_comb begin
      state_d = state_q;
      case (state_q)
         ohv_pkg::OHV_S_OFF: begin
            if (runAllowed) begin
               state_d = ohv_pkg::OHV_S_SOFT;
            end
         end
         ohv_pkg::OHV_S_SOFT: begin
            if (!runAllowed) begin
               state_d = ohv_pkg::OHV_S_OFF;
            end else if (ocEvt) begin
               state_d = ohv_pkg::OHV_S_WAIT;
            end else if (rampDone) begin
               state_d = ohv_pkg::OHV_S_RUN;
            end
         end
         ohv_pkg::OHV_S_RUN: begin
            if (!runAllowed) begin
               state_d = ohv_pkg::OHV_S_OFF;
            end else if (ocEvt) begin
               state_d = ohv_pkg::OHV_S_WAIT;
            end
         end
         ohv_pkg::OHV_S_WAIT: begin
            if (!runAllowed) begin
               state_d = ohv_pkg::OHV_S_OFF;
            end else if (swTick && (wait_q == waitLen_q - 1'b1)) begin
               state_d = ohv_pkg::OHV_S_SOFT;
            end
         end
         default: begin
            state_d = ohv_pkg::OHV_S_OFF;
         end
      endcase
   end

   // state register; no retry count, so the loop never latches off
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state_q <= ohv_pkg::OHV_S_OFF;
      end else begin
         state_q <= state_d;
      end
   end

   // wait length chosen by where the event struck
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         waitLen_q <= WAIT_W'(FIRST_WAIT);
      end else if (ocEvt && state_q == ohv_pkg::OHV_S_RUN) begin
         waitLen_q <= WAIT_W'(FIRST_WAIT);
      end else if (ocEvt && state_q == ohv_pkg::OHV_S_SOFT) begin
         waitLen_q <= WAIT_W'(RETRY_WAIT);
      end
   end

   // wait counter in switching cycles
   always_ff @(posedge clk) begin
      if (!rst_b || state_q != ohv_pkg::OHV_S_WAIT) begin
         wait_q <= '0;
      end else if (swTick) begin
         wait_q <= wait_q + 1'b1;
      end
   end

   // ********************
   // soft-start ramp
   // ********************
   // a delay, then one 12.5 mV step per ramp period
   always_ff @(posedge clk) begin
      if (!rst_b || state_q != ohv_pkg::OHV_S_SOFT) begin
         ss_q <= '0;
         ssDelayDone_q <= 1'b0;
         ramp_q <= '0;
      end else if (swTick) begin
         if (!ssDelayDone_q) begin
            if (ss_q == SS_W'(SS_DELAY - 1)) begin
               ss_q <= '0;
               ssDelayDone_q <= 1'b1;
            end else begin
               ss_q <= ss_q + 1'b1;
            end
         end else if (ss_q == SS_W'(SS_STEP - 1)) begin
            ss_q <= '0;
            if (ramp_q < refSteps) begin
               ramp_q <= ramp_q + 1'b1;
            end
         end else begin
            ss_q <= ss_q + 1'b1;
         end
      end
   end

   // ramp shown at full level once running
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rampLevel <= '0;
      end else if (state_q == ohv_pkg::OHV_S_RUN) begin
         rampLevel <= refSteps;
      end else begin
         rampLevel <= ramp_q;
      end
   end

   // ********************
   // gate drives
   // ********************
   // the next state gates the drives, so an event turns them off
   // on the same edge that sees it
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         highGate <= 2'h0;
         lowGate <= 2'h0;
      end else if (state_d == ohv_pkg::OHV_S_SOFT || state_d == ohv_pkg::OHV_S_RUN) begin
         highGate <= pwmDemand;
         lowGate <= ~pwmDemand;
      end else begin
         highGate <= 2'h0;
         lowGate <= 2'h0;
      end
   end

   // ********************
   // status outputs
   // ********************
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         overcurrentEvent <= 1'b0;
         hiccupActive <= 1'b0;
      end else begin
         overcurrentEvent <= ocEvt;
         hiccupActive <= (state_d == ohv_pkg::OHV_S_WAIT);
      end
   end

   // sticky event flag; a new event wins over a clear
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         sticky_q <= 1'b0;
      end else if (ocEvt) begin
         sticky_q <= 1'b1;
      end else if (wbWrite && wb_adr_i == `OHV_ADR_STATUS && wb_sel_i[0]
            && wb_dat_i[`OHV_ST_STICKY]) begin
         sticky_q <= 1'b0;
      end
   end

   // ********************
   // wishbone slave
   // ********************
   assign wbReq = wb_cyc_i && wb_stb_i;
   assign wbWrite = wbReq && wb_we_i && ack_q;
   assign wb_ack_o = ack_q;

   // one wait cycle, ack for one cycle
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= wbReq && !ack_q;
      end
   end

   // control register, low byte lane
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ctrlEn_q <= `OHV_CTRL_EN_RESET;
         tbl_q <= ohv_pkg::ohv_table_t'(`OHV_CTRL_TBL_RESET);
      end else if (wbWrite && wb_adr_i == `OHV_ADR_CTRL && wb_sel_i[0]) begin
         ctrlEn_q <= wb_dat_i[`OHV_CTRL_EN];
         tbl_q <= ohv_pkg::ohv_table_t'(wb_dat_i[`OHV_CTRL_TBL_MSB:`OHV_CTRL_TBL_LSB]);
      end
   end

   // read decode; unmapped offsets read zero
   always_comb begin
      rdData = 32'h0000_0000;
      if (wb_adr_i == `OHV_ADR_CTRL) begin
         rdData[`OHV_CTRL_EN] = ctrlEn_q;
         rdData[`OHV_CTRL_TBL_MSB:`OHV_CTRL_TBL_LSB] = tbl_q;
      end else if (wb_adr_i == `OHV_ADR_STATUS) begin
         rdData[`OHV_ST_STICKY] = sticky_q;
         rdData[`OHV_ST_HICCUP] = (state_q == ohv_pkg::OHV_S_WAIT);
         rdData[`OHV_ST_FLAG_LSB +: 2] = ocSync;
         rdData[`OHV_ST_STATE_LSB +: 2] = state_q;
      end else if (wb_adr_i == `OHV_ADR_VCODE) begin
         rdData[5:0] = vcodeBit;
         rdData[`OHV_VC_STEPS_LSB +: `OHV_STEP_W] = refSteps;
         rdData[`OHV_VC_OFF] = codeOff;
      end else if (wb_adr_i == `OHV_ADR_WAIT) begin
         rdData[WAIT_W-1:0] = wait_q;
      end
   end

   // read data registered with the ack
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (wbReq && !ack_q && !wb_we_i) begin
         wb_dat_o <= rdData;
      end
   end
endmodule : ohv_hiccup_top

// [pkg/ohv_consts.svh]
// constants for the overcurrent hiccup and voltage code block
// assumes inclusion by bare name; holds definitions only
`ifndef OHV_CONSTS_SVH
`define OHV_CONSTS_SVH

// ********************
// clock rates and timing counts
// ********************
`define OHV_CLK_KHZ 50000
`define OHV_SW_KHZ 222
// system clocks per switching cycle, rounded down
`define OHV_SW_DIV ((`OHV_CLK_KHZ) / (`OHV_SW_KHZ))
`define OHV_FIRST_WAIT 4096
`define OHV_RETRY_WAIT 2048
`define OHV_PERSIST_CYC 7
`define OHV_SS_DELAY 16
`define OHV_SS_STEP 16

// ********************
// register byte offsets
// ********************
`define OHV_ADR_CTRL 8'h00
`define OHV_ADR_STATUS 8'h04
`define OHV_ADR_VCODE 8'h08
`define OHV_ADR_WAIT 8'h0c

// ********************
// field positions and reset values
// ********************
`define OHV_CTRL_EN 0
`define OHV_CTRL_TBL_LSB 1
`define OHV_CTRL_TBL_MSB 2
`define OHV_CTRL_EN_RESET 1'b0
`define OHV_CTRL_TBL_RESET 2'h0
`define OHV_ST_STICKY 0
`define OHV_ST_HICCUP 1
`define OHV_ST_FLAG_LSB 2
`define OHV_ST_STATE_LSB 4
`define OHV_VC_STEPS_LSB 8
`define OHV_VC_OFF 16
`define OHV_STEP_W 8

`endif

// [pkg/ohv_pkg.sv]
// types shared by the overcurrent hiccup and voltage code block
// assumes nothing beyond a SystemVerilog compiler
package ohv_pkg;
   // code table choice; the fourth value decodes as off
   typedef enum logic [1:0] {
      OHV_TBL_FIRST5,
      OHV_TBL_SECOND5,
      OHV_TBL_FINE6,
      OHV_TBL_NONE
   } ohv_table_t;

   // supervision states
   typedef enum logic [1:0] {
      OHV_S_OFF,
      OHV_S_SOFT,
      OHV_S_RUN,
      OHV_S_WAIT
   } ohv_state_t;
endpackage : ohv_pkg

// [verilog/ohv_sync.sv]
// two flip-flop synchroniser for pin inputs
// assumes one clock and a synchronous active-low reset
`timescale 1ns/10ps
module ohv_sync #(
   parameter int WIDTH = 1,
   parameter logic RESET_VAL = 1'b0
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // pin side and clocked side
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] meta_q;

   if (WIDTH < 1) begin : gBadWidth
      $error("ohv_sync: WIDTH must be at least one");
   end

   // first stage feeds only the second stage
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         meta_q <= {WIDTH{RESET_VAL}};
         syncOut <= {WIDTH{RESET_VAL}};
      end else begin
         meta_q <= asyncIn;
         syncOut <= meta_q;
      end
   end
endmodule : ohv_sync

// [verilog/ohv_code_decode.sv]
// voltage code decoder: code word to 12.5 mV reference steps
// assumes a synchronised code word and a table choice
`timescale 1ns/10ps
`include "ohv_consts.svh"
module ohv_code_decode (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // code in, bit five is the fine bit
   input wire logic [5:0] vcodeBit,
   input wire ohv_pkg::ohv_table_t tableSel,
   // decoded reference
   output logic codeOff_q,
   output logic [`OHV_STEP_W-1:0] steps_q
);
   logic [5:0] fineWord;
   logic offD;
   logic [`OHV_STEP_W-1:0] stepsD;

   // 5-bit table: 11111 off, each decrement adds 25 mV (two steps)
   function automatic logic [`OHV_STEP_W-1:0] decode5(input logic [4:0] c,
         input logic [`OHV_STEP_W-1:0] base);
      decode5 = base + {2'h0, 5'h1e - c, 1'b0};
   endfunction : decode5

   // 6-bit table, bit five least significant; two runs of 12.5 mV codes
   function automatic logic [`OHV_STEP_W-1:0] decodeFine(input logic [5:0] w);
      if (w <= 6'h14) begin
         decodeFine = 8'h57 - {2'h0, w};
      end else begin
         decodeFine = 8'h95 - {2'h0, w};
      end
   endfunction : decodeFine

   assign fineWord = {vcodeBit[4:0], vcodeBit[5]};

   // table choice and off codes
   always_comb begin
      offD = 1'b0;
      stepsD = 8'h00;
      case (tableSel)
         ohv_pkg::OHV_TBL_FIRST5: begin
            offD = &vcodeBit[4:0];
            stepsD = decode5(vcodeBit[4:0], 8'h40);
         end
         ohv_pkg::OHV_TBL_SECOND5: begin
            offD = &vcodeBit[4:0];
            stepsD = decode5(vcodeBit[4:0], 8'h58);
         end
         ohv_pkg::OHV_TBL_FINE6: begin
            offD = &fineWord[5:1];
            stepsD = decodeFine(fineWord);
         end
         default: begin
            offD = 1'b1;
         end
      endcase
      if (offD) begin
         stepsD = 8'h00;
      end
   end

   // registered result
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         codeOff_q <= 1'b1;
         steps_q <= 8'h00;
      end else begin
         codeOff_q <= offD;
         steps_q <= stepsD;
      end
   end
endmodule : ohv_code_decode

// [dv/ohv_hiccup_checker.sv]
// concurrent checks on the hiccup supervisor ports
// assumes one clock and a synchronous active-low reset
`timescale 1ns/10ps
module ohv_hiccup_checker #(
   parameter int SW_DIV = 4,
   parameter int FIRST_WAIT = 16,
   parameter int RETRY_WAIT = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // wishbone
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // drives, reference, status
   input wire logic [1:0] highGate,
   input wire logic [1:0] lowGate,
   input wire logic [7:0] referenceLevel,
   input wire logic referenceOff,
   input wire logic overcurrentEvent,
   input wire logic hiccupActive
);
   localparam int MINW = (RETRY_WAIT - 1) * SW_DIV;
   localparam int MAXW = (FIRST_WAIT + 1) * SW_DIV + 1;
   logic [15:0] waitLen_q;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);

   // length of the current all-off wait in clocks
   always_ff @(posedge clk) begin
      waitLen_q <= (!rst_b || !hiccupActive) ? 16'h0 : waitLen_q + 16'h1;
   end

   // ********************
   // assertions
   // ********************
   gates_off_a: assert property (
      hiccupActive |-> highGate == 2'h0 && lowGate == 2'h0) else $error("drive on in wait");
   event_hold_a: assert property (
      overcurrentEvent |-> hiccupActive [*4]) else $error("wait not held after event");
   event_pulse_a: assert property (
      overcurrentEvent |=> !overcurrentEvent) else $error("event longer than a cycle");
   wait_cause_a: assert property (
      $rose(hiccupActive) |-> overcurrentEvent) else $error("wait without event");
   wait_len_a: assert property (
      $fell(hiccupActive) |-> waitLen_q >= MINW && waitLen_q <= MAXW)
      else $error("wait length out of range");
   no_overlap_a: assert property (
      (highGate & lowGate) == 2'h0) else $error("both drives of a channel on");
   off_ref_a: assert property (
      referenceOff |-> referenceLevel == 8'h0) else $error("reference set on off code");
   off_gates_a: assert property (
      referenceOff [*4] |-> highGate == 2'h0 && lowGate == 2'h0) else $error("drive on code");
   ack_pulse_a: assert property (
      wb_ack_o |=> !wb_ack_o) else $error("ack longer than a cycle");
   ack_cause_a: assert property (
      $rose(wb_ack_o) |-> $past(wb_stb_i)) else $error("ack without request");
   unmapped_read_a: assert property (
      wb_ack_o && !wb_we_i && wb_adr_i > 8'h0c |-> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");

   // main scenarios reached
   cover property (overcurrentEvent);
   cover property ($fell(hiccupActive));
   cover property (wb_ack_o && wb_we_i);
endmodule : ohv_hiccup_checker

bind ohv_hiccup_top ohv_hiccup_checker #(.SW_DIV(SW_DIV), .FIRST_WAIT(FIRST_WAIT),
   .RETRY_WAIT(RETRY_WAIT)) u_chk (.clk(clk), .rst_b(rst_b), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .highGate(highGate), .lowGate(lowGate), .referenceLevel(referenceLevel),
   .referenceOff(referenceOff), .overcurrentEvent(overcurrentEvent),
   .hiccupActive(hiccupActive));

// [dv/ohv_far_model.sv]
// power stage comparators, pwm source and code driver
// assumes the bench changes requests just after a rising edge
`timescale 1ns/10ps
module ohv_far_model (
   // clock
   input wire logic clk,
   // requests from the bench
   input wire logic [1:0] flagReq,
   input wire logic [5:0] codeReq,
   input wire logic [5:0] codeDriven,
   // pins toward the block
   output logic [1:0] ocFlag,
   output logic [5:0] vcodeLevel,
   output logic [5:0] vcodeDrive,
   output logic [1:0] pwmDemand
);
   logic [3:0] phase_q = 4'h0;

   // free-running phase for pwm and the released-pin pattern
   always_ff @(posedge clk) begin
      phase_q <= phase_q + 4'h1;
   end
   // comparator flags follow the bench
   assign ocFlag = flagReq;
   // released pins show a changing level, never a stale one
   assign vcodeLevel = (codeReq & codeDriven) | (~codeDriven & {6{phase_q[0]}});
   assign vcodeDrive = codeDriven;
   // two channels half a period apart
   assign pwmDemand = {phase_q[3], ~phase_q[3]};
endmodule : ohv_far_model

// [dv/ohv_hiccup_top_tb.sv]
// self-checking bench for the hiccup supervisor
// assumes shortened waits and the far-side model beside the block
`timescale 1ns/10ps
module ohv_hiccup_top_tb;
   localparam int DIV = 4;
   localparam int FW = 16;
   localparam int RW = 8;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, enPin = 1'b1, ack, refOff, ocEv, hicc;
   logic [7:0] adr = 8'h0, refLvl, ramp;
   logic [3:0] sel = 4'h0;
   logic [31:0] dat = 32'h0, datO, r;
   logic [1:0] flagReq = 2'h0, ocFlag, pwmDemand, highGate, lowGate;
   logic [5:0] codeReq = 6'h1e, codeDriven = 6'h3f, vcodeLevel, vcodeDrive;
   int n_fail = 0, compares = 0, evCount = 0, n, m;

   // ********************
   // clock, block, far side
   // ********************
   always #10 clk = ~clk;
   // events seen, for checks that none happened
   always @(posedge clk) if (ocEv === 1'b1) evCount++;
   ohv_hiccup_top #(.SW_DIV(DIV), .FIRST_WAIT(FW), .RETRY_WAIT(RW), .PERSIST(7),
      .SS_DELAY(2), .SS_STEP(2)) u_dut (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
      .wb_dat_o(datO), .wb_ack_o(ack), .ocFlag(ocFlag), .enablePin(enPin),
      .vcodeLevel(vcodeLevel), .vcodeDrive(vcodeDrive), .pwmDemand(pwmDemand),
      .highGate(highGate), .lowGate(lowGate), .referenceLevel(refLvl), .rampLevel(ramp),
      .referenceOff(refOff), .overcurrentEvent(ocEv), .hiccupActive(hicc));
   ohv_far_model u_far (.clk(clk), .flagReq(flagReq), .codeReq(codeReq),
      .codeDriven(codeDriven), .ocFlag(ocFlag), .vcodeLevel(vcodeLevel),
      .vcodeDrive(vcodeDrive), .pwmDemand(pwmDemand));

   // ********************
   // shared tasks
   // ********************
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // one classic cycle, entered just after an edge; read data lands in r
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      int k;
      k = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      sel <= s;
      do begin
         @(posedge clk);
         k++;
      end while (ack !== 1'b1 && k < 50);
      if (k == 50) n_fail++;
      r = datO;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask : wb

   // decoded reference {off, steps} for a table and a pin word
   function automatic logic [8:0] expRef(input int t, input int c);
      int w;
      int v;
      w = ((c & 31) << 1) | (c >> 5);
      v = 256;
      if (t == 0 && (c & 31) != 31) v = 64 + 2 * (30 - (c & 31));
      if (t == 1 && (c & 31) != 31) v = 88 + 2 * (30 - (c & 31));
      if (t == 2 && w < 62) v = (w <= 20) ? 87 - w : 149 - w;
      return 9'(v);
   endfunction : expRef

   // poll status until the run state shows
   task waitRun;
      int k;
      k = 0;
      do begin
         wb(1'b0, 8'h04, 32'h0, 4'hf);
         k++;
      end while (r[5:4] !== 2'h2 && k < 400);
      chk(r[5:4], 2'h2);
      chk(ramp, refLvl);
   endtask : waitRun

   // edges to the event, then clocks of wait; flags drop unless kept
   task evLen(input logic keep);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ocEv !== 1'b1 && n < 100);
      if (!keep) flagReq <= 2'h0;
      chk({highGate, lowGate}, 4'h0);
      m = 0;
      while (hicc === 1'b1 && m < 200) begin
         @(posedge clk);
         m++;
      end
   endtask : evLen

   task summarize;
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : summarize

   // ********************
   // scenarios
   // ********************
   task tReset;
      wb(1'b0, 8'h00, 32'h0, 4'hf);
      chk(r, 32'h0);
      wb(1'b1, 8'h10, 32'hffffffff, 4'hf);
      wb(1'b0, 8'h10, 32'h0, 4'hf);
      chk(r, 32'h0);
      flagReq <= 2'h3;
      repeat (10) @(posedge clk);
      flagReq <= 2'h0;
      chk(evCount, 0);
   endtask : tReset

   task tDecode;
      for (int t = 0; t < 4; t++) begin
         wb(1'b1, 8'h00, 32'(t * 2 + 1), 4'hf);
         for (int c = 0; c < 64; c++) begin
            codeReq <= 6'(c);
            repeat (6) @(posedge clk);
            chk({refOff, refLvl}, expRef(t, c));
         end
      end
      wb(1'b1, 8'h00, 32'h1, 4'hf);
      codeDriven <= 6'h3e;
      codeReq <= 6'h00;
      repeat (6) @(posedge clk);
      chk({refOff, refLvl}, expRef(0, 1));
      codeDriven <= 6'h00;
      repeat (6) @(posedge clk);
      chk({refOff, refLvl}, expRef(0, 63));
      codeDriven <= 6'h3f;
      codeReq <= 6'h1e;
      wb(1'b1, 8'h00, 32'h0, 4'h0);
      wb(1'b0, 8'h00, 32'h0, 4'hf);
      chk(r, 32'h1);
   endtask : tDecode

   task tFirst;
      flagReq <= 2'h3;
      evLen(1'b0);
      chk(n, 4);
      chk(m >= (FW - 1) * DIV && m <= FW * DIV + 1, 1'b1);
      waitRun();
      chk(r[0], 1'b1);
      wb(1'b1, 8'h04, 32'h1, 4'hf);
      wb(1'b0, 8'h04, 32'h0, 4'hf);
      chk(r[0], 1'b0);
   endtask : tFirst

   task tRetry;
      flagReq <= 2'h3;
      for (int i = 0; i < 4; i++) begin
         evLen(i < 3);
         if (i == 0) chk(m >= (FW - 1) * DIV && m <= FW * DIV + 1, 1'b1);
         else chk(m >= (RW - 1) * DIV && m <= RW * DIV + 1, 1'b1);
      end
      waitRun();
   endtask : tRetry

   task tSingle;
      int e0;
      e0 = evCount;
      flagReq <= 2'h1;
      repeat (6 * DIV) @(posedge clk);
      flagReq <= 2'h0;
      @(posedge clk);
      flagReq <= 2'h1;
      repeat (6 * DIV) @(posedge clk);
      flagReq <= 2'h0;
      repeat (8) @(posedge clk);
      chk(evCount, e0);
      flagReq <= 2'h2;
      evLen(1'b0);
      chk(n >= 7 * DIV && n <= 8 * DIV + 4, 1'b1);
      waitRun();
   endtask : tSingle

   task tOffCode;
      codeReq <= 6'h1f;
      repeat (8) @(posedge clk);
      chk({refOff, refLvl, highGate, lowGate}, 13'h1000);
      wb(1'b0, 8'h04, 32'h0, 4'hf);
      chk(r[5:4], 2'h0);
      codeReq <= 6'h1e;
      enPin <= 1'b0;
      repeat (8) @(posedge clk);
      wb(1'b0, 8'h04, 32'h0, 4'hf);
      chk(r[5:4], 2'h0);
      enPin <= 1'b1;
      waitRun();
   endtask : tOffCode

   // ********************
   // main sequence and watchdog
   // ********************
   initial begin
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      tReset();
      tDecode();
      waitRun();
      tFirst();
      tRetry();
      tSingle();
      tOffCode();
      summarize();
   end

   initial begin
      repeat (40000) @(posedge clk);
      n_fail++;
      summarize();
   end
endmodule : ohv_hiccup_top_tb
